// [rtl/swsc_pkg.sv]
// package: constants and types for the sleep, wake and swap controller
package swsc_pkg;
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned SWAP_LOW_MS      = 200;
  localparam int unsigned SWAP_LOW_CYC     = SWAP_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_TIMEOUT_MS  = 1000;
  localparam int unsigned WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned RESET_PIN_NS     = 100;
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RESET_PIN_CYC    =
    (RESET_PIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_TIMEOUT_CYC = 20_000_000;
  localparam int unsigned CLK_LOSS_CYC     = 64;
  localparam int unsigned DEBOUNCE_CYC     = 100_000;
  localparam logic [6:0]  I2C_ADDR_DEFAULT = 7'h61;
  localparam int unsigned CNT_W            = 32;
  localparam int unsigned RST_CNT_W        = 4;
  localparam int unsigned BOOT_W           = 3;
  localparam int unsigned BOOT_PINS        = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    SWSC_MODE_ACTIVE,
    SWSC_MODE_BYPASS,
    SWSC_MODE_STANDBY,
    SWSC_MODE_SLEEP
  } swsc_mode_e;

  typedef enum logic [1:0] {
    SWSC_SLEEP_NONE,
    SWSC_SLEEP_CMD,
    SWSC_SLEEP_CLK
  } swsc_cause_e;
endpackage

// [rtl/swsc_timer.sv]
// module: saturating cycle counter that pulses once when a condition has held long enough
`timescale 1ns/1ps
module swsc_timer import swsc_pkg::*; #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      hit_o,
  output logic      done_o
);
  logic [CNT_W-1:0] cnt_reg;

  // counting stops at the limit so one qualifying period gives one pulse only
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= CNT_ZERO;
      hit_o   <= 1'b0;
    end else if (cnt_reg < CNT_W'(LIMIT)) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
      hit_o   <= (cnt_reg == CNT_W'(LIMIT - 1));
    end else begin
      hit_o   <= 1'b0;
    end
  end

  assign done_o = (cnt_reg >= CNT_W'(LIMIT));
endmodule // swsc_timer

// [rtl/swsc_ctrl.sv]
// module: operating mode, wake timeout, clock loss, swap, reset and watchdog control
`timescale 1ns/1ps
module swsc_ctrl import swsc_pkg::*; (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      hard_reset_pin_n_i,
  input  wire logic                      external_clock_in_i,
  input  wire logic                      scl_activity_i,
  input  wire logic                      cmd_valid_i,
  input  wire swsc_mode_e                cmd_mode_i,
  input  wire logic                      wdog_service_i,
  input  wire logic                      output_swap_pin_i,
  input  wire logic [BOOT_PINS*BOOT_W-1:0] boot_level_adc_i,
  output swsc_mode_e                     mode_o,
  output logic                           processing_en_o,
  output logic                           core_on_lowspeed_osc_o,
  output logic                           swap_channels_o,
  output logic                           system_reset_o,
  output logic [BOOT_PINS*BOOT_W-1:0]    boot_config_o,
  output logic                           boot_config_valid_o,
  output logic [6:0]                     i2c_addr_o,
  output logic                           clock_lost_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset sources
  logic pin_low_hit;
  logic pin_low_done;
  logic wdog_hit;
  logic sys_rst;
  logic wdog_run;

  swsc_timer #(.LIMIT(RESET_PIN_CYC)) u_pin_rst (
    .clk_i  (clk_i),
    .rst_i  (1'b0),
    .run_i  (!hard_reset_pin_n_i),
    .hit_o  (pin_low_hit),
    .done_o (pin_low_done)
  );

  // reset is held while the pin stays low once the minimum has passed
  assign sys_rst = rst_i || pin_low_done || system_reset_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_reset_o <= 1'b1;
    end else begin
      system_reset_o <= pin_low_hit || pin_low_done || wdog_hit;
    end
  end

  // no enable input: the watchdog cannot be switched off
  assign wdog_run = !wdog_service_i && !sys_rst;

  swsc_timer #(.LIMIT(WDOG_TIMEOUT_CYC)) u_wdog (
    .clk_i  (clk_i),
    .rst_i  (sys_rst),
    .run_i  (wdog_run),
    .hit_o  (wdog_hit),
    .done_o ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // boot capture
  logic boot_done_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      boot_done_reg       <= 1'b0;
      boot_config_valid_o <= 1'b0;
      boot_config_o       <= '0;
    end else if (!boot_done_reg) begin
      boot_done_reg       <= 1'b1;
      boot_config_valid_o <= 1'b1;
      boot_config_o       <= boot_level_adc_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      i2c_addr_o <= I2C_ADDR_DEFAULT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock-loss detection
  logic external_clock_in_d_reg;
  logic ext_edge;
  logic loss_done;

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      external_clock_in_d_reg <= 1'b0;
    end else begin
      external_clock_in_d_reg <= external_clock_in_i;
    end
  end

  assign ext_edge = external_clock_in_i && !external_clock_in_d_reg;

  // counts oscillator cycles since the last external rising edge
  swsc_timer #(.LIMIT(CLK_LOSS_CYC)) u_loss (
    .clk_i  (clk_i),
    .rst_i  (sys_rst),
    .run_i  (!ext_edge),
    .hit_o  (),
    .done_o (loss_done)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      clock_lost_o <= 1'b0;
    end else begin
      clock_lost_o <= loss_done && !ext_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  swsc_mode_e  mode_reg;
  swsc_mode_e  mode_next;
  swsc_cause_e cause_reg;
  swsc_cause_e cause_next;
  logic        woken_reg;
  logic        woken_next;
  logic        wake_to_hit;

  // timeout runs only in standby reached by bus activity
  swsc_timer #(.LIMIT(WAKE_TIMEOUT_CYC)) u_wake_to (
    .clk_i  (clk_i),
    .rst_i  (sys_rst),
    .run_i  (mode_reg == SWSC_MODE_STANDBY && woken_reg),
    .hit_o  (wake_to_hit),
    .done_o ()
  );

  always_comb begin
    mode_next  = mode_reg;
    cause_next = cause_reg;
    woken_next = woken_reg;
    case (mode_reg)
      SWSC_MODE_ACTIVE, SWSC_MODE_BYPASS: begin
        // level, not pulse: a clock already gone when active is entered still sends it to sleep
        if (loss_done) begin
          mode_next  = SWSC_MODE_SLEEP;
          cause_next = SWSC_SLEEP_CLK;
        end else if (cmd_valid_i && cmd_mode_i != SWSC_MODE_STANDBY) begin
          mode_next  = cmd_mode_i;
          cause_next = (cmd_mode_i == SWSC_MODE_SLEEP) ? SWSC_SLEEP_CMD : SWSC_SLEEP_NONE;
        end
      end
      SWSC_MODE_STANDBY: begin
        if (wake_to_hit) begin
          mode_next  = SWSC_MODE_SLEEP;
          cause_next = SWSC_SLEEP_CMD;
          woken_next = 1'b0;
        end else if (cmd_valid_i && cmd_mode_i != SWSC_MODE_STANDBY) begin
          mode_next  = cmd_mode_i;
          cause_next = (cmd_mode_i == SWSC_MODE_SLEEP) ? SWSC_SLEEP_CMD : SWSC_SLEEP_NONE;
          woken_next = 1'b0;
        end
      end
      SWSC_MODE_SLEEP: begin
        if (cause_reg == SWSC_SLEEP_CLK) begin
          if (ext_edge) begin
            mode_next  = SWSC_MODE_ACTIVE;
            cause_next = SWSC_SLEEP_NONE;
          end
        end else if (scl_activity_i) begin
          mode_next  = SWSC_MODE_STANDBY;
          woken_next = 1'b1;
        end
      end
      default: begin
        mode_next  = SWSC_MODE_SLEEP;
        cause_next = SWSC_SLEEP_CMD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      mode_reg  <= SWSC_MODE_ACTIVE;
      cause_reg <= SWSC_SLEEP_NONE;
      woken_reg <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      cause_reg <= cause_next;
      woken_reg <= woken_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      mode_o                 <= SWSC_MODE_ACTIVE;
      processing_en_o        <= 1'b0;
      core_on_lowspeed_osc_o <= 1'b0;
    end else begin
      mode_o                 <= mode_next;
      processing_en_o        <= (mode_next == SWSC_MODE_ACTIVE) ||
                                (mode_next == SWSC_MODE_BYPASS);
      core_on_lowspeed_osc_o <= (mode_next == SWSC_MODE_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel swap
  logic swap_stable_reg;
  logic deb_hit;
  logic swap_hit;

  // a short debounce settles the pin before the long low count starts
  swsc_timer #(.LIMIT(DEBOUNCE_CYC)) u_deb (
    .clk_i  (clk_i),
    .rst_i  (sys_rst),
    .run_i  (output_swap_pin_i != swap_stable_reg),
    .hit_o  (deb_hit),
    .done_o ()
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      swap_stable_reg <= 1'b1;
    end else if (deb_hit) begin
      swap_stable_reg <= output_swap_pin_i;
    end
  end

  // trade-off: swap fires at the end of the window, allowed anywhere inside it
  // debounce and pipeline cycles come off the low count so the toggle lands inside the window
  swsc_timer #(.LIMIT(SWAP_LOW_CYC - DEBOUNCE_CYC - 2)) u_swap (
    .clk_i  (clk_i),
    .rst_i  (sys_rst),
    .run_i  (!output_swap_pin_i && !swap_stable_reg),
    .hit_o  (swap_hit),
    .done_o ()
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      swap_channels_o <= 1'b0;
    end else if (swap_hit) begin
      swap_channels_o <= !swap_channels_o;
    end
  end

endmodule // swsc_ctrl

// [verification/swsc_ctrl_sva.sv]
// checker: port-level properties of the sleep, wake and swap controller
`timescale 1ns/1ps
module swsc_ctrl_sva import swsc_pkg::*; (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        hard_reset_pin_n_i,
  input wire logic        external_clock_in_i,
  input wire logic        scl_activity_i,
  input wire logic        cmd_valid_i,
  input wire swsc_mode_e  cmd_mode_i,
  input wire swsc_mode_e  mode_o,
  input wire logic        processing_en_o,
  input wire logic        core_on_lowspeed_osc_o,
  input wire logic        system_reset_o,
  input wire logic [11:0] boot_config_o,
  input wire logic        boot_config_valid_o,
  input wire logic [6:0]  i2c_addr_o,
  input wire logic        clock_lost_o
);
  logic       ext_q_reg;
  logic [7:0] idle_reg;
  // cycles since the external clock last changed; saturates so a long stop never wraps
  always_ff @(posedge clk_i) begin
    ext_q_reg <= external_clock_in_i;
    if (rst_i || external_clock_in_i != ext_q_reg) idle_reg <= 8'h00;
    else if (idle_reg != 8'hFF) idle_reg <= idle_reg + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || system_reset_o);
  cmd_sleep_a: assert property (cmd_valid_i && cmd_mode_i == SWSC_MODE_SLEEP &&
    mode_o != SWSC_MODE_SLEEP |=> mode_o == SWSC_MODE_SLEEP) else $error("sleep not taken");
  cmd_select_a: assert property (cmd_valid_i && cmd_mode_i inside {SWSC_MODE_ACTIVE,
    SWSC_MODE_BYPASS} && mode_o != SWSC_MODE_SLEEP && !clock_lost_o
    |=> mode_o == $past(cmd_mode_i)) else $error("mode select lost");
  standby_ignored_a: assert property (cmd_valid_i && cmd_mode_i == SWSC_MODE_STANDBY &&
    mode_o != SWSC_MODE_SLEEP && !clock_lost_o |=> $stable(mode_o)) else $error("standby taken");
  sleep_hold_a: assert property (mode_o == SWSC_MODE_SLEEP && !scl_activity_i
    |=> mode_o != SWSC_MODE_STANDBY) else $error("woke without bus activity");
  scl_wake_a: assert property (mode_o == SWSC_MODE_SLEEP && scl_activity_i && !clock_lost_o
    && !$past(clock_lost_o) |=> mode_o == SWSC_MODE_STANDBY) else $error("bus wake missed");
  loss_sleep_a: assert property (clock_lost_o && mode_o inside {SWSC_MODE_ACTIVE,
    SWSC_MODE_BYPASS} |-> ##[0:2] mode_o == SWSC_MODE_SLEEP) else $error("no loss sleep");
  loss_detect_a: assert property (idle_reg == 8'h48 |-> clock_lost_o)
    else $error("clock loss not flagged");
  pin_reset_a: assert property (disable iff (rst_i) !hard_reset_pin_n_i [*2] |=> ##1 system_reset_o)
    else $error("pin reset missed");
  addr_default_a: assert property (i2c_addr_o == 7'h61)
    else $error("bus address wrong");
  sleep_core_a: assert property (mode_o == SWSC_MODE_SLEEP [*2]
    |-> core_on_lowspeed_osc_o && !processing_en_o) else $error("sleep outputs wrong");
  boot_hold_a: assert property (boot_config_valid_o && $past(boot_config_valid_o)
    |-> $stable(boot_config_o)) else $error("boot config changed");
endmodule // swsc_ctrl_sva

bind swsc_ctrl swsc_ctrl_sva swsc_ctrl_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
  .hard_reset_pin_n_i(hard_reset_pin_n_i), .external_clock_in_i(external_clock_in_i),
  .scl_activity_i(scl_activity_i), .cmd_valid_i(cmd_valid_i), .cmd_mode_i(cmd_mode_i),
  .mode_o(mode_o), .processing_en_o(processing_en_o), .system_reset_o(system_reset_o),
  .core_on_lowspeed_osc_o(core_on_lowspeed_osc_o), .boot_config_o(boot_config_o),
  .boot_config_valid_o(boot_config_valid_o), .i2c_addr_o(i2c_addr_o),
  .clock_lost_o(clock_lost_o));

// [verification/swsc_host_model.sv]
// partner model: host issuing mode-change commands and bus wake activity
`timescale 1ns/1ps
module swsc_host_model import swsc_pkg::*; (
  input  wire logic       clk_i,
  input  wire swsc_mode_e mode_i,
  output logic            cmd_valid_o,
  output swsc_mode_e      cmd_mode_o,
  output logic            scl_activity_o
);
  initial begin
    cmd_valid_o = 1'h0;
    cmd_mode_o = SWSC_MODE_ACTIVE;
    scl_activity_o = 1'h0;
  end
  task automatic send_cmd(swsc_mode_e m);
    @(negedge clk_i);
    cmd_valid_o = 1'h1;
    cmd_mode_o = m;
    @(negedge clk_i);
    cmd_valid_o = 1'h0;
  endtask
  // uninterpreted traffic; only the bus clock activity matters to the device
  task automatic nop();
    @(negedge clk_i);
    scl_activity_o = 1'h1;
    @(negedge clk_i);
    scl_activity_o = 1'h0;
  endtask
  // short poll keeps the whole wake far inside the timeout
  task automatic wake(swsc_mode_e m);
    nop();
    for (int i = 0; i < 20 && mode_i !== SWSC_MODE_STANDBY; i++) @(negedge clk_i);
    send_cmd(m);
  endtask
endmodule // swsc_host_model

// [verification/swsc_ctrl_test.sv]
// testbench: directed tests of the sleep, wake and swap controller
`timescale 1ns/1ps
module swsc_ctrl_test import swsc_pkg::*; ;
  logic        clk = 1'h0, rst = 1'h1, pin_n = 1'h1, ext = 1'h0, ext_run = 1'h1;
  logic        wdog = 1'h0, swap_n = 1'h1, cv, scl, proc_en, lowosc, swp, srst, bok, lost;
  logic [1:0]  ph = 2'h0;
  logic [11:0] boot = 12'h05A3, boot_q;
  logic [6:0]  addr;
  swsc_mode_e  cm, mode;
  int          bad_count = 0, n_compared = 0;
  initial forever #25 clk = ~clk;
  // external clock at an eighth of the core rate; stops where a test asks
  always @(negedge clk) begin
    wdog <= ~wdog;
    if (ext_run) ph <= ph + 2'h1;
    if (ext_run && ph == 2'h3) ext <= ~ext;
  end
  swsc_host_model host_inst (.clk_i(clk), .mode_i(mode), .cmd_valid_o(cv),
    .cmd_mode_o(cm), .scl_activity_o(scl));
  swsc_ctrl swsc_ctrl_inst (.clk_i(clk), .rst_i(rst), .hard_reset_pin_n_i(pin_n),
    .external_clock_in_i(ext), .scl_activity_i(scl), .cmd_valid_i(cv), .cmd_mode_i(cm),
    .wdog_service_i(wdog), .output_swap_pin_i(swap_n), .boot_level_adc_i(boot),
    .mode_o(mode), .processing_en_o(proc_en), .core_on_lowspeed_osc_o(lowosc),
    .swap_channels_o(swp), .system_reset_o(srst), .boot_config_o(boot_q),
    .boot_config_valid_o(bok), .i2c_addr_o(addr), .clock_lost_o(lost));
  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_mode(swsc_mode_e m, int n);
    for (int i = 0; i < n && mode !== m; i++) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    check("addr", 12'(addr), 12'h0061);
    check("boot", boot_q, 12'h05A3);
    check("boot valid", 12'(bok), 12'h0001);
    boot = 12'h0A5C;
    swap_n = 1'h0;
    repeat (50) @(negedge clk);
    swap_n = 1'h1;
    repeat (4) @(negedge clk);
    check("boot held", boot_q, 12'h05A3);
    check("swap glitch", 12'(swp), 12'h0000);
    $display("test boot done");
    host_inst.send_cmd(SWSC_MODE_SLEEP);
    check("sleep", 12'(mode), 12'(SWSC_MODE_SLEEP));
    repeat (2) @(negedge clk);
    check("low osc", 12'(lowosc), 12'h0001);
    check("proc off", 12'(proc_en), 12'h0000);
    host_inst.wake(SWSC_MODE_BYPASS);
    check("wake", 12'(mode), 12'(SWSC_MODE_BYPASS));
    check("proc on", 12'(proc_en), 12'h0001);
    check("osc off", 12'(lowosc), 12'h0000);
    host_inst.send_cmd(SWSC_MODE_STANDBY);
    check("standby", 12'(mode), 12'(SWSC_MODE_BYPASS));
    host_inst.send_cmd(SWSC_MODE_ACTIVE);
    check("active", 12'(mode), 12'(SWSC_MODE_ACTIVE));
    $display("test command sleep done");
    ext_run = 1'h0;
    wait_mode(SWSC_MODE_SLEEP, 100);
    check("loss sleep", 12'(mode), 12'(SWSC_MODE_SLEEP));
    check("lost", 12'(lost), 12'h0001);
    host_inst.nop();
    repeat (3) @(negedge clk);
    check("scl ignored", 12'(mode), 12'(SWSC_MODE_SLEEP));
    ext_run = 1'h1;
    wait_mode(SWSC_MODE_ACTIVE, 30);
    check("clock back", 12'(mode), 12'(SWSC_MODE_ACTIVE));
    $display("test clock loss done");
    pin_n = 1'h0;
    repeat (4) @(negedge clk);
    check("pin reset", 12'(srst), 12'h0001);
    pin_n = 1'h1;
    repeat (6) @(negedge clk);
    check("boot reread", boot_q, 12'h0A5C);
    check("mode reset", 12'(mode), 12'(SWSC_MODE_ACTIVE));
    $display("test pin reset done");
    end_sim;
  end
endmodule // swsc_ctrl_test
